//--- rtl/ppio_pkg.sv
package ppio_pkg;
  // control port field positions, strobe line count, fifo width and depth
  localparam int CODE_LSB = 0;
  localparam int CODE_W   = 4;
  localparam int ENA_N    = 4;
  localparam int DIR_RP   = 5;
  localparam int DIR_PP   = 6;
  localparam int IRQ_BIT  = 7;
  localparam int NSTROBE  = 13;
  localparam int FIFO_W   = 8;
  localparam int FIFO_D   = 16;
  // idle control byte: decoder off, every buffer pair to output
  localparam logic [7:0] CTL_IDLE  = 8'h7F;
  localparam logic [7:0] DATA_IDLE = 8'hFF;
  // strobe codes
  localparam logic [3:0] SC_PROM_W0   = 4'h0;
  localparam logic [3:0] SC_PROM_W2   = 4'h1;
  localparam logic [3:0] SC_PROM_W1   = 4'h2;
  localparam logic [3:0] SC_PROM_RD   = 4'h3;
  localparam logic [3:0] SC_PROM_ST   = 4'h4;
  localparam logic [3:0] SC_PROM_RST  = 4'h5;
  localparam logic [3:0] SC_PUNCH     = 4'h6;
  localparam logic [3:0] SC_RD_LEFT   = 4'h7;
  localparam logic [3:0] SC_RD_RIGHT  = 4'h8;
  localparam logic [3:0] SC_LPT_DATA  = 4'h9;
  localparam logic [3:0] SC_LPT_CTL1  = 4'hA;
  localparam logic [3:0] SC_LPT_CTL2  = 4'hB;
  localparam logic [3:0] SC_STAT_EN   = 4'hC;
  // peripheral operation kinds
  typedef enum logic [1:0] {
    PPIO_OP_OUT    = 2'h0,
    PPIO_OP_PROMIN = 2'h1,
    PPIO_OP_RDRIN  = 2'h2,
    PPIO_OP_STATIN = 2'h3
  } ppio_op_t;
endpackage

//--- rtl/ppio_if.sv
`timescale 1ns/100ps
`default_nettype none
// host select/strobe bus plus the four shared flags
interface ppio_if;
  logic       port_select_n;
  logic       host_rd_n;
  logic       host_wr_n;
  logic       host_addr_lsb;
  logic [7:0] host_wdata;
  logic [7:0] host_rdata;
  logic       in_buf_full;
  logic       out_buf_full;
  logic       slave_busy_flag;
  logic       cmd_data_flag;
  logic       host_irq;
  logic       drv_to_host;
  modport dev (input port_select_n, host_rd_n, host_wr_n, host_addr_lsb, host_wdata,
               output host_rdata, in_buf_full, out_buf_full, slave_busy_flag,
               cmd_data_flag, host_irq, drv_to_host);
  modport host (output port_select_n, host_rd_n, host_wr_n, host_addr_lsb, host_wdata,
                input host_rdata, in_buf_full, out_buf_full, slave_busy_flag,
                cmd_data_flag, host_irq, drv_to_host);
endinterface
`default_nettype wire

//--- rtl/ppio_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// small synchronous fifo, refuses writes when full
module ppio_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;
  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- rtl/ppio_dev.sv
`timescale 1ns/100ps
`default_nettype none
module ppio_dev (
  input  wire logic             clk,
  input  wire logic             rst_n,
  ppio_if.dev                   hb,
  input  wire logic             op_valid,
  output logic                  op_ready,
  input  wire ppio_pkg::ppio_op_t op_kind,
  input  wire logic [3:0]       op_code,
  input  wire logic [7:0]       op_data,
  output logic                  in_valid,
  output logic [7:0]            in_byte,
  output logic                  in_is_cmd,
  input  wire logic             in_take,
  input  wire logic             out_load,
  input  wire logic [7:0]       out_byte,
  input  wire logic             out_is_status,
  input  wire logic             busy_set,
  input  wire logic             busy_clr,
  output logic [7:0]            data_o,
  output logic [7:0]            data_oe,
  input  wire logic [7:0]       data_i,
  output logic [7:0]            ctl_port,
  output logic [12:0]           strobe_n,
  output logic                  dir_rp_out,
  output logic                  dir_pp_out,
  output logic                  dir_lpt_out,
  output logic                  rd_valid,
  output logic [7:0]            rd_byte
);
  typedef enum logic [2:0] {
    PPIO_S_IDLE = 3'b000,
    PPIO_S_DEF  = 3'b001,
    PPIO_S_ENA  = 3'b011,
    PPIO_S_DIS  = 3'b010,
    PPIO_S_RDIR = 3'b110,
    PPIO_S_RD   = 3'b111
  } ppio_st_t;

  ppio_st_t           st;
  ppio_pkg::ppio_op_t kind;
  logic [7:0]         ctl;
  logic [7:0]         s1_d;
  logic [7:0]         s2_d;
  logic [7:0]         s1_c;
  logic [7:0]         s2_c;
  logic               s1_w;
  logic               s2_w;
  logic               s3_w;
  logic               s1_s;
  logic               s2_s;
  logic               s1_r;
  logic               s2_r;
  logic               s3_r;
  logic               s1_a;
  logic               s2_a;
  logic [7:0]         rd_sync1;
  logic [7:0]         rd_sync2;
  logic               f_in_valid;
  logic               f_in_ready;
  logic [8:0]         f_out;
  logic               f_out_valid;
  logic [12:0]        next_strobe_n;

  // one-hot active-low decode of the strobe code
  function automatic logic [12:0] ppio_decode(input logic [7:0] c);
    logic [12:0] s;
    s = '1;
    if (!c[ppio_pkg::ENA_N] && c[3:0] <= ppio_pkg::SC_STAT_EN) begin
      s[c[3:0]] = 1'b0;
    end
    return s;
  endfunction

  // control byte with the decoder off, the given code and both direction bits as passed
  function automatic logic [7:0] ppio_ctl(input logic [3:0] code, input logic rp,
                                          input logic pp);
    logic [7:0] c;
    c = ppio_pkg::CTL_IDLE;
    c[3:0] = code;
    c[ppio_pkg::DIR_RP] = rp;
    c[ppio_pkg::DIR_PP] = pp;
    return c;
  endfunction

  // host pins pass two flops, read and write strobes three; strobes come from another domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {s1_w, s2_w, s3_w, s1_r, s2_r, s3_r} <= 6'h3F;
      {s1_s, s2_s, s1_a, s2_a} <= 4'hF;
      {s1_d, s2_d} <= 16'h0000;
      {rd_sync1, rd_sync2} <= 16'h0000;
    end else begin
      s1_w <= hb.host_wr_n;
      s2_w <= s1_w;
      s3_w <= s2_w;
      s1_r <= hb.host_rd_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
      s1_s <= hb.port_select_n;
      s2_s <= s1_s;
      s1_a <= hb.host_addr_lsb;
      s2_a <= s1_a;
      s1_d <= hb.host_wdata;
      s2_d <= s1_d;
      rd_sync1 <= data_i;
      rd_sync2 <= rd_sync1;
    end
  end

  // host writes land in the fifo; rising edge of write ends the cycle
  assign f_in_valid = !s2_s && s2_w && !s3_w;
  ppio_fifo #(.W(ppio_pkg::FIFO_W + 1), .D(ppio_pkg::FIFO_D)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   ({s2_a, s2_d}),
    .out_valid (f_out_valid),
    .out_ready (in_take),
    .out_data  (f_out)
  );
  assign in_valid  = f_out_valid;
  assign in_byte   = f_out[7:0];
  assign in_is_cmd = f_out[8];

  // shared flags; a set in the clear cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hb.in_buf_full     <= 1'b0;
      hb.out_buf_full    <= 1'b0;
      hb.slave_busy_flag <= 1'b0;
      hb.cmd_data_flag   <= 1'b0;
      hb.host_rdata      <= 8'h00;
    end else begin
      hb.in_buf_full <= !f_in_ready;
      if (out_load) begin
        hb.out_buf_full  <= 1'b1;
        hb.host_rdata    <= out_byte;
        hb.cmd_data_flag <= out_is_status;
      end else if (!s2_s && s2_r && !s3_r) begin
        hb.out_buf_full <= 1'b0;
      end else if (f_in_valid) begin
        hb.cmd_data_flag <= s2_a;
      end
      if (busy_set) begin
        hb.slave_busy_flag <= 1'b1;
      end else if (busy_clr) begin
        hb.slave_busy_flag <= 1'b0;
      end
    end
  end

  // host drivers face the host only while its read is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hb.drv_to_host <= 1'b0;
    end else begin
      hb.drv_to_host <= !s2_s && !s2_r;
    end
  end

  // peripheral sequencer; one control byte per state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st     <= PPIO_S_IDLE;
      kind   <= ppio_pkg::PPIO_OP_OUT;
      ctl    <= ppio_pkg::CTL_IDLE;
      data_o <= ppio_pkg::DATA_IDLE;
      rd_valid <= 1'b0;
      rd_byte  <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      case (st)
        PPIO_S_IDLE: begin
          ctl    <= ppio_pkg::CTL_IDLE;
          data_o <= ppio_pkg::DATA_IDLE;
          if (op_valid) begin
            kind <= op_kind;
            if (op_kind == ppio_pkg::PPIO_OP_OUT) begin
              data_o <= op_data;
            end
            st <= PPIO_S_DEF;
          end
        end
        PPIO_S_DEF: begin
          case (kind)
            ppio_pkg::PPIO_OP_OUT: begin
              ctl <= ppio_ctl(op_code, 1'b1, 1'b1);
              st  <= PPIO_S_ENA;
            end
            ppio_pkg::PPIO_OP_PROMIN: begin
              ctl <= ppio_ctl(op_code, 1'b1, 1'b0);
              st  <= PPIO_S_ENA;
            end
            ppio_pkg::PPIO_OP_STATIN: begin
              ctl <= ppio_ctl(ppio_pkg::SC_STAT_EN, 1'b1, 1'b1);
              st  <= PPIO_S_ENA;
            end
            default: begin
              ctl <= ppio_ctl(op_code, 1'b0, 1'b1);
              st  <= PPIO_S_RDIR;
            end
          endcase
        end
        PPIO_S_ENA: begin
          ctl[ppio_pkg::ENA_N] <= 1'b0;
          st <= (kind == ppio_pkg::PPIO_OP_OUT) ? PPIO_S_DIS : PPIO_S_RD;
        end
        PPIO_S_RDIR: begin
          st <= PPIO_S_RD; // let the buffer turn round
        end
        PPIO_S_RD: begin
          rd_valid <= 1'b1;
          rd_byte  <= rd_sync2;
          st       <= (kind == ppio_pkg::PPIO_OP_RDRIN) ? PPIO_S_IDLE : PPIO_S_DIS;
        end
        PPIO_S_DIS: begin
          ctl[ppio_pkg::ENA_N] <= 1'b1;
          st <= PPIO_S_IDLE;
        end
        default: begin
          st <= PPIO_S_IDLE;
        end
      endcase
    end
  end

  assign op_ready = (st == PPIO_S_IDLE);
  assign next_strobe_n = ppio_decode(ctl);

  // registered decode plus the three direct controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_n    <= '1;
      ctl_port    <= ppio_pkg::CTL_IDLE;
      dir_rp_out  <= 1'b1;
      dir_pp_out  <= 1'b1;
      dir_lpt_out <= 1'b1;
      hb.host_irq <= 1'b0;
      data_oe     <= 8'hFF;
    end else begin
      strobe_n    <= next_strobe_n;
      ctl_port    <= ctl;
      dir_rp_out  <= ctl[ppio_pkg::DIR_RP];
      dir_pp_out  <= ctl[ppio_pkg::DIR_PP];
      dir_lpt_out <= next_strobe_n[ppio_pkg::SC_STAT_EN];
      hb.host_irq <= ctl[ppio_pkg::IRQ_BIT];
      // quasi-bidirectional port: drive while idle and while a byte goes out
      data_oe     <= (kind == ppio_pkg::PPIO_OP_OUT || st == PPIO_S_IDLE) ? 8'hFF : 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ppio_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side: turns simple requests into select/strobe cycles
module ppio_host (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ppio_if.host            hb,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_write,
  input  wire logic       req_cmd,
  input  wire logic [7:0] req_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic [3:0]      flags
);
  localparam logic [3:0] HOLD = 4'h6; // strobe width, covers the device's sync stages
  typedef enum logic [1:0] {
    PPIO_H_IDLE = 2'b00,
    PPIO_H_STB  = 2'b01,
    PPIO_H_END  = 2'b11
  } ppio_hst_t;
  ppio_hst_t  st;
  logic [3:0] cnt;
  logic       wr;
  logic [3:0] f1;
  logic [3:0] f2;

  // flags come from the device clock domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f1    <= 4'h0;
      f2    <= 4'h0;
      flags <= 4'h0;
    end else begin
      f1    <= {hb.cmd_data_flag, hb.slave_busy_flag, hb.out_buf_full, hb.in_buf_full};
      f2    <= f1;
      flags <= f2;
    end
  end

  // access sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st               <= PPIO_H_IDLE;
      cnt              <= 4'h0;
      wr               <= 1'b0;
      hb.port_select_n <= 1'b1;
      hb.host_rd_n     <= 1'b1;
      hb.host_wr_n     <= 1'b1;
      hb.host_addr_lsb <= 1'b0;
      hb.host_wdata    <= 8'h00;
      rsp_valid        <= 1'b0;
      rsp_data         <= 8'h00;
      req_ready        <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (st)
        PPIO_H_IDLE: begin
          if (req_valid && req_ready) begin
            req_ready        <= 1'b0;
            wr               <= req_write;
            hb.port_select_n <= 1'b0;
            hb.host_addr_lsb <= req_cmd;
            hb.host_wdata    <= req_data;
            hb.host_wr_n     <= !req_write;
            hb.host_rd_n     <= req_write;
            cnt              <= HOLD;
            st               <= PPIO_H_STB;
          end
        end
        PPIO_H_STB: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            if (!wr) begin
              rsp_data  <= hb.host_rdata;
              rsp_valid <= 1'b1;
            end
            hb.host_wr_n <= 1'b1;
            hb.host_rd_n <= 1'b1;
            cnt          <= HOLD;
            st           <= PPIO_H_END;
          end
        end
        PPIO_H_END: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            hb.port_select_n <= 1'b1;
            req_ready        <= 1'b1;
            st               <= PPIO_H_IDLE;
          end
        end
        default: begin
          st <= PPIO_H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- sim/ppio_properties.sv
`timescale 1ns/100ps
`default_nettype none
// link and control-port timing seen from outside both ends
module ppio_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               host_rd_n,
  input wire logic               host_irq,
  input wire logic               drv_to_host,
  input wire logic               op_valid,
  input wire logic               op_ready,
  input wire ppio_pkg::ppio_op_t op_kind,
  input wire logic [3:0]         op_code,
  input wire logic [7:0]         op_data,
  input wire logic [7:0]         data_o,
  input wire logic [7:0]         ctl_port,
  input wire logic [12:0]        strobe_n,
  input wire logic               dir_lpt_out
);
  logic [7:0]  cq;
  logic [3:0]  kq;
  logic [7:0]  dq;
  logic        rq;
  logic        sq;
  logic [12:0] dec_n;
  logic [12:0] exp_n;
  // last control byte; idle during reset so the first edges stay quiet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cq <= ppio_pkg::CTL_IDLE;
      rq <= 1'b0;
      sq <= 1'b1;
    end else begin
      cq <= ctl_port;
      rq <= op_ready;
      sq <= strobe_n[12];
    end
  end
  // code and byte of the operation in flight
  always_ff @(posedge clk) begin
    if (op_valid && op_ready) begin
      kq <= op_code;
      dq <= op_data;
    end
  end
  // codes above twelve shift out, so every line stays high
  assign dec_n = ~(13'h1 << ctl_port[3:0]);
  assign exp_n = ~(13'h1 << kq);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_out_take;
    op_valid && op_ready && op_kind == ppio_pkg::PPIO_OP_OUT;
  endsequence
  // code first with decoder off, then only enable drops; strobe registers beside the port
  sequence s_out_pulse;
    ctl_port[6:0] == {3'h7, kq}
      ##1 ctl_port[6:0] == {3'h6, kq} && strobe_n == exp_n && data_o == dq;
  endsequence
  property p_out;
    s_out_take |=> data_o == dq ##2 s_out_pulse ##1 &strobe_n;
  endproperty
  a_out: assert property (p_out) else $error("output sequence broken");
  property p_dec_off;
    ctl_port[4] |-> &strobe_n;
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("strobe while decoder off");
  property p_decode;
    !ctl_port[4] |-> strobe_n == dec_n;
  endproperty
  a_decode: assert property (p_decode) else $error("wrong strobe line");
  property p_two_step;
    (!ctl_port[4] && cq[4]) |-> (ctl_port ^ cq) == 8'h10;
  endproperty
  a_two_step: assert property (p_two_step) else $error("enable moved with other bits");
  property p_idle;
    (op_ready && rq && $past(op_ready, 2)) |->
      ctl_port[6:4] == 3'h7 && data_o == ppio_pkg::DATA_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("pins not idle between operations");
  property p_lpt;
    (strobe_n[12] && sq) |-> dir_lpt_out;
  endproperty
  a_lpt: assert property (p_lpt) else $error("printer pair turned without status strobe");
  property p_irq;
    (ctl_port[7] == cq[7]) |-> host_irq == ctl_port[7];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt differs from control bit");
  property p_drv;
    host_rd_n [*4] |-> !drv_to_host;
  endproperty
  a_drv: assert property (p_drv) else $error("drivers face host without read");
endmodule
`default_nettype wire

//--- sim/tb_peripheral_parallel_io_port.sv
`timescale 1ns/100ps
`default_nettype none
// both ends joined by the link; the bench plays host software and peripherals
module tb_peripheral_parallel_io_port;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               op_valid = 1'b0;
  ppio_pkg::ppio_op_t op_kind = ppio_pkg::PPIO_OP_OUT;
  logic [3:0]         op_code = 4'h0;
  logic [7:0]         op_data = 8'h00;
  logic [3:0]         pls = 4'h0;
  logic [7:0]         out_byte = 8'h00;
  logic               out_is_status = 1'b0;
  logic               req_valid = 1'b0;
  logic               req_write = 1'b0;
  logic               req_cmd = 1'b0;
  logic [7:0]         req_data = 8'h00;
  logic [7:0]         pdrv = 8'hFF;
  logic               op_ready, in_valid, in_is_cmd, rd_valid, req_ready, rsp_valid;
  logic               dir_rp_out, dir_pp_out, dir_lpt_out, lpt_in;
  logic [7:0]         in_byte, data_o, data_oe, ctl_port, rd_byte, rsp_data, rd, dseen, rseen;
  logic [3:0]         flags;
  logic [12:0]        strobe_n, ev;
  logic [12:0]        lowv = 13'h0;
  int                 nlow = 0;
  int                 mismatches = 0;
  int                 checks = 0;
  wire logic [7:0]    data_i;
  ppio_if hb ();
  // driven ones act as pull-ups, so a peripheral can still pull lines low
  assign data_i = (~data_oe | data_o) & pdrv;
  always #12.5 clk = ~clk;
  ppio_dev ppio_dev_inst (
    .clk, .rst_n, .hb, .op_valid, .op_ready, .op_kind, .op_code, .op_data, .in_valid,
    .in_byte, .in_is_cmd, .in_take(pls[3]), .out_load(pls[0]), .out_byte, .out_is_status,
    .busy_set(pls[1]), .busy_clr(pls[2]), .data_o, .data_oe, .data_i, .ctl_port, .strobe_n,
    .dir_rp_out, .dir_pp_out, .dir_lpt_out, .rd_valid, .rd_byte);
  ppio_host ppio_host_inst (
    .clk, .rst_n, .hb, .req_valid, .req_ready, .req_write, .req_cmd, .req_data, .rsp_valid,
    .rsp_data, .flags);
  ppio_chk ppio_chk_inst (
    .clk, .rst_n, .host_rd_n(hb.host_rd_n), .host_irq(hb.host_irq),
    .drv_to_host(hb.drv_to_host), .op_valid, .op_ready, .op_kind, .op_code, .op_data,
    .data_o, .ctl_port, .strobe_n, .dir_lpt_out);
  // per operation: lines strobed, strobe cycles, pin byte, returned byte
  always @(posedge clk) begin
    lowv = lowv | ~strobe_n;
    if (strobe_n !== 13'h1FFF) begin
      nlow++;
      dseen = data_o;
    end
    if (dir_lpt_out === 1'b0) lpt_in = 1'b1;
    if (rd_valid === 1'b1) rseen = rd_byte;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded wait on one condition, sampled away from the active edge
  task automatic await(input int i);
    logic [8:0] s;
    for (int n = 0; n < 500; n++) begin
      @(negedge clk);
      s = {hb.in_buf_full, !flags[2], flags[2], !flags[1], flags[1], rsp_valid, in_valid,
           req_ready, op_ready};
      if (s[i] === 1'b1) return;
    end
    mismatches++;
    close_out();
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pls[i] <= 1'b1;
    @(posedge clk);
    pls[i] <= 1'b0;
  endtask
  task automatic start(input ppio_pkg::ppio_op_t k, input logic [3:0] c,
                       input logic [7:0] d, input logic [7:0] p);
    await(0);
    lowv = 13'h0;
    nlow = 0;
    lpt_in = 1'b0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_code <= c;
    op_data <= d;
    pdrv <= p;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask
  task automatic op(input ppio_pkg::ppio_op_t k, input logic [3:0] c,
                    input logic [7:0] d, input logic [7:0] p);
    start(k, c, d, p);
    await(0);
    repeat (2) @(negedge clk);
    pdrv <= 8'hFF;
  endtask
  task automatic host(input logic w, input logic c, input logic [7:0] d);
    await(1);
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_cmd <= c;
    req_data <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    if (!w) begin
      await(3);
      rd = rsp_data;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({ctl_port, data_o}, 16'h7FFF);
    chk(strobe_n, 13'h1FFF);
    chk({dir_rp_out, dir_pp_out, dir_lpt_out, hb.host_irq}, 4'hE);
    chk(flags, 4'h0);
    $display("test reset done");
    // every code, one at a time with idle pins between; codes above twelve strobe nothing
    for (int c = 0; c < 16; c++) begin
      ev = 13'h1 << c;
      op(ppio_pkg::PPIO_OP_OUT, c[3:0], 8'hA0 + c[7:0], 8'hFF);
      chk(lowv, ev);
      chk(nlow[15:0], 16'(c < 13));
      if (c < 13) chk(dseen, 8'hA0 + c[7:0]);
      chk({ctl_port[6:4], data_o}, 11'h7FF);
    end
    $display("test output done");
    op(ppio_pkg::PPIO_OP_RDRIN, 4'h0, 8'h00, 8'h3C);
    chk(rseen, 8'h3C);
    chk(nlow[15:0], 16'h0);
    op(ppio_pkg::PPIO_OP_PROMIN, 4'h3, 8'h00, 8'h96);
    chk(rseen, 8'h96);
    chk(lowv, 13'h0008);
    op(ppio_pkg::PPIO_OP_STATIN, 4'hC, 8'h00, 8'h4B);
    chk(rseen, 8'h4B);
    chk({lpt_in, lowv}, 14'h3000);
    $display("test input done");
    // reset lands before the strobe would have fired
    start(ppio_pkg::PPIO_OP_OUT, 4'h6, 8'h55, 8'hFF);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({ctl_port, data_o}, 16'h7FFF);
    chk(strobe_n, 13'h1FFF);
    $display("test abort done");
    for (int k = 0; k < 2; k++) begin
      host(1'b1, k[0], 8'h5A ^ k[7:0]);
      await(2);
      chk({in_is_cmd, in_byte}, {k[0], 8'h5A ^ k[7:0]});
      pulse(3);
    end
    @(posedge clk);
    out_byte <= 8'hC3;
    out_is_status <= 1'b1;
    pulse(0);
    await(4);
    chk(flags[3], 1'b1);
    host(1'b0, 1'b0, 8'h00);
    chk(rd, 8'hC3);
    await(5);
    chk(hb.out_buf_full, 1'b0);
    pulse(1);
    await(6);
    chk(hb.slave_busy_flag, 1'b1);
    pulse(2);
    await(7);
    chk(hb.slave_busy_flag, 1'b0);
    $display("test host link done");
    // seventeen writes into sixteen places while nothing drains
    for (int k = 0; k < 17; k++) host(1'b1, 1'b0, k[7:0]);
    await(1);
    repeat (4) @(negedge clk);
    chk({hb.in_buf_full, flags[0]}, 2'h3);
    for (int k = 0; k < 16; k++) begin
      await(2);
      chk(in_byte, k[7:0]);
      pulse(3);
    end
    @(negedge clk);
    chk(in_valid, 1'b0);
    $display("test buffer done");
    close_out();
  end
endmodule
`default_nettype wire
